/* File: include/crs_params.svh */
// Purpose: constants of the programmer register set
// Assumes: apb byte addresses, one aligned word per register
// Notes:   flag positions follow the condition code layout
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

`define CRS_ADDR_W       8
`define CRS_OFF_ACC      8'h00
`define CRS_OFF_IDX      8'h04
`define CRS_OFF_PC       8'h08
`define CRS_OFF_SP       8'h0C
`define CRS_OFF_FLAGS    8'h10
`define CRS_OFF_PEND     8'h14

`define CRS_FLAG_W       5
`define CRS_FLG_H        4
`define CRS_FLG_I        3
`define CRS_FLG_N        2
`define CRS_FLG_Z        1
`define CRS_FLG_C        0
`define CRS_FLAGS_RST    5'h08

`define CRS_ACC_RST      8'h00
`define CRS_IDX_RST      8'h00
`define CRS_PC_RST       16'h0000
`define CRS_SP_LOW_W     6
`define CRS_SP_TOP       6'h3F
`define CRS_SP_BASE      10'h003
`define CRS_CALL_BYTES   6'h02
`define CRS_INT_BYTES    6'h05
`define CRS_NIB_MAX      5'h0F

`define CRS_IRQ_N        4
`define CRS_IRQ_EXT      0
`define CRS_IRQ_TMR      1
`define CRS_IRQ_SCI      2
`define CRS_IRQ_SPI      3

`endif

/* File: include/crs_pkg.sv */
// Purpose: types of the programmer register set
// Assumes: constants come from crs_params.svh
// Notes:   core control and apb signals travel as packed structs
`include "crs_params.svh"
package crs_pkg;
    typedef enum logic [2:0] {
        STK_NONE, STK_PUSH, STK_PULL, STK_CALL, STK_RET, STK_INTE, STK_RTI, STK_REINIT
    } crs_stk_t;

    typedef struct packed {
        logic        loadAcc;
        logic [7:0]  accData;
        logic        loadIdx;
        logic [7:0]  idxData;
        logic        loadPc;
        logic [15:0] pcData;
        logic        incPc;
        crs_stk_t    stkOp;
    } crs_ctl_t;

    typedef struct packed {
        logic [4:0]  affect;
        logic [7:0]  result;
        logic        addOp;
        logic [7:0]  opA;
        logic [7:0]  opB;
        logic        carryIn;
        logic        carryOut;
        logic        maskVal;
    } crs_flg_upd_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } crs_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } crs_apb_rsp_t;
endpackage

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the programmer register set
// Assumes: zero wait-state apb, core strobes taken each rising edge
// Notes:   reads note expectations in a queue, a monitor compares them
`timescale 1ns/1ps
module tb_top;
    import crs_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  resetn  = 1'b0;
    crs_pkg::crs_ctl_t     ctl     = '0;
    crs_pkg::crs_flg_upd_t flgUpd  = '0;
    logic [3:0]            irqReq  = 4'h0;
    logic                  intAck  = 1'b0;
    crs_pkg::crs_apb_req_t apbReq  = '0;
    crs_pkg::crs_apb_rsp_t apbRsp;
    logic [7:0]            accOut;
    logic [7:0]            idxOut;
    logic [15:0]           pcOut;
    logic [15:0]           stackAddr;
    logic [4:0]            flagsOut;
    logic [3:0]            serviceVec;
    logic                  serviceReq;
    logic [32:0]           expQ[$];
    int                    fail_count = 0;
    int                    n_compared = 0;

    crs_regset u_crs_regset (.sys_clk(sys_clk), .resetn(resetn), .ctl(ctl), .flgUpd(flgUpd),
        .irqReq(irqReq), .intAck(intAck), .apbReq(apbReq), .apbRsp(apbRsp),
        .accOut(accOut), .idxOut(idxOut), .pcOut(pcOut), .stackAddr(stackAddr),
        .flagsOut(flagsOut), .serviceVec(serviceVec), .serviceReq(serviceReq));

    always #10 sys_clk = ~sys_clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // read results compared in order of issue
    always @(posedge sys_clk) begin
        if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
            check({apbRsp.pslverr, apbRsp.prdata}, expQ.pop_front());
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!w) expQ.push_back(e);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= w;
        apbReq.paddr   <= a;
        apbReq.pwdata  <= d;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        @(posedge sys_clk);
        while (apbRsp.pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 20) begin
            fail_count++;
            stop_test();
        end
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic step(input crs_ctl_t c, input crs_flg_upd_t f);
        ctl    <= c;
        flgUpd <= f;
        @(posedge sys_clk);
        ctl    <= '0;
        flgUpd <= '0;
    endtask

    crs_stk_t    ops[9] = '{STK_PUSH, STK_CALL, STK_INTE, STK_RTI, STK_RET, STK_PULL,
                            STK_PULL, STK_PUSH, STK_REINIT};
    logic [15:0] exs[9] = '{16'h00FE, 16'h00FC, 16'h00F7, 16'h00FC, 16'h00FE, 16'h00FF,
                            16'h00C0, 16'h00FF, 16'h00FF};

    initial begin
        crs_ctl_t     c;
        crs_flg_upd_t f;
        logic [7:0]   a;
        logic [7:0]   x;
        logic [15:0]  p;
        logic         ci;
        logic         h;
        void'($urandom(44947));
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(`CRS_OFF_ACC, 32'h0);
        rd(`CRS_OFF_IDX, 32'h0);
        rd(`CRS_OFF_PC, 32'h0);
        rd(`CRS_OFF_SP, 32'h00FF);
        rd(`CRS_OFF_FLAGS, 32'h08);
        rd(`CRS_OFF_PEND, 32'h0);
        apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            c = '0;
            c.stkOp = ops[i];
            step(c, '0);
            rd(`CRS_OFF_SP, {16'h0, exs[i]});
            check(33'(stackAddr), 33'(exs[i]));
        end
        c = '0;
        c.stkOp = STK_PUSH;
        ctl <= c;
        repeat (64) @(posedge sys_clk);
        ctl <= '0;
        rd(`CRS_OFF_SP, 32'h00FF);
        ctl <= c;
        @(posedge sys_clk);
        c.stkOp = STK_PULL;
        ctl <= c;
        @(posedge sys_clk);
        ctl <= '0;
        rd(`CRS_OFF_SP, 32'h00FF);
        c.stkOp = STK_PUSH;
        step(c, '0);
        apb(1'b1, `CRS_OFF_SP, 32'h0000_0012, 33'h0);
        rd(`CRS_OFF_SP, 32'h00FF);
        $display("test stack done");
        irqReq <= 4'hF;
        @(posedge sys_clk);
        irqReq <= 4'h0;
        @(negedge sys_clk);
        check(33'({serviceReq, serviceVec}), 33'h0);
        @(posedge sys_clk);
        rd(`CRS_OFF_PEND, 32'hF);
        apb(1'b1, `CRS_OFF_FLAGS, 32'h0, 33'h0);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            check(33'({serviceReq, serviceVec}), 33'({1'b1, 4'(1 << i)}));
            @(posedge sys_clk);
            intAck <= 1'b1;
            @(posedge sys_clk);
            intAck <= 1'b0;
        end
        @(negedge sys_clk);
        check(33'(serviceReq), 33'h0);
        @(posedge sys_clk);
        irqReq <= 4'h2;
        c = '0;
        c.stkOp = STK_INTE;
        step(c, '0);
        irqReq <= 4'h0;
        @(negedge sys_clk);
        check(33'({serviceReq, flagsOut}), 33'h08);
        $display("test interrupt done");
        @(posedge sys_clk);
        apb(1'b1, `CRS_OFF_FLAGS, 32'h0, 33'h0);
        step('0, '{5'h17, 8'h10, 1'b1, 8'h0F, 8'h01, 1'b0, 1'b0, 1'b0});
        rd(`CRS_OFF_FLAGS, 32'h10);
        step('0, '{5'h06, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0});
        rd(`CRS_OFF_FLAGS, 32'h12);
        step('0, '{5'h01, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0});
        rd(`CRS_OFF_FLAGS, 32'h13);
        step('0, '{5'h0E, 8'h80, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1});
        rd(`CRS_OFF_FLAGS, 32'h1D);
        $display("test flags done");
        for (int i = 0; i < 8; i++) begin
            a  = 8'($urandom);
            x  = 8'($urandom);
            p  = 16'($urandom);
            ci = 1'($urandom);
            h  = ({1'b0, a[3:0]} + {1'b0, x[3:0]} + {4'h0, ci}) > `CRS_NIB_MAX;
            c = '0;
            c.loadAcc = 1'b1;
            c.accData = a;
            c.loadIdx = 1'b1;
            c.idxData = x;
            c.loadPc  = 1'b1;
            c.pcData  = p;
            c.incPc   = 1'b1;
            f = '{5'h10, a, 1'b1, a, x, ci, 1'b0, 1'b0};
            step(c, f);
            rd(`CRS_OFF_ACC, {24'h0, a});
            rd(`CRS_OFF_IDX, {24'h0, x});
            rd(`CRS_OFF_PC, {16'h0, p});
            rd(`CRS_OFF_FLAGS, {27'h0, h, 4'hD});
            check(33'({accOut, idxOut, pcOut}), 33'({a, x, p}));
            c = '0;
            c.incPc = 1'b1;
            step(c, '0);
            rd(`CRS_OFF_PC, {16'h0, 16'(p + 16'h1)});
            apb(1'b1, `CRS_OFF_IDX, {24'h0, a}, 33'h0);
            rd(`CRS_OFF_IDX, {24'h0, a});
        end
        $display("test random done");
        @(posedge sys_clk);
        check(33'(expQ.size()), 33'h0);
        stop_test();
    end
endmodule

/* File: verilog/crs_flag_bit.sv */
// Purpose: one condition flag with hardware and software update
// Assumes: hardware update outranks a software write in the same cycle
// Notes:   holds its value when neither update is active
`timescale 1ns/1ps
module crs_flag_bit #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic hwEn,
    input  wire logic hwVal,
    input  wire logic swEn,
    input  wire logic swVal,
    output logic      flag
);
    logic flag_q;
    logic flag_d;

    assign flag_d = hwEn ? hwVal : (swEn ? swVal : flag_q);
    assign flag   = flag_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= RST_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule

/* File: verilog/crs_regset.sv */
// Purpose: programmer register set with apb access and interrupt gating
// Assumes: core control strobes are synchronous to sys_clk
// Notes:   core updates outrank apb writes to the same register
`timescale 1ns/1ps
`include "crs_params.svh"
// Operation
// - An 8-bit accumulator holds operands and results of data operations.
// - An 8-bit index register supplies the indexed offset and may hold temporary data.
// - A 16-bit fetch pointer always holds the address of the next byte to fetch.
// - Reset and the stack reinit op load the stack pointer with the top location 0FF.
// - The stack pointer falls on each push and rises on each pull, naming the next free byte.
// - Stack addresses carry the fixed ten-bit upper pattern 0000000011 above six pointer bits.
// - Beyond 64 stack bytes the pointer wraps inside the stack area without any error.
// - A subroutine call takes two stack bytes and an interrupt entry takes five.
// - The status flags are five bits, four for results and one mask, each readable.
// - Add operations set the nibble carry flag on a carry from bit 3 into bit 4.
// - While the mask flag is set, timer, serial, peripheral and external requests wait.
// - A request arriving while masked is held and served once the mask clears.
// - The negative flag follows bit 7 of the last result.
// - The zero flag is set when the last result is zero and cleared otherwise.
// - The carry flag records a carry or borrow out of the arithmetic unit.
// - Bit-test-branch and shift or rotate operations also update the carry flag.
module crs_regset (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire crs_pkg::crs_ctl_t     ctl,
    input  wire crs_pkg::crs_flg_upd_t flgUpd,
    input  wire logic [3:0]           irqReq,
    input  wire logic                 intAck,
    input  wire crs_pkg::crs_apb_req_t apbReq,
    output crs_pkg::crs_apb_rsp_t     apbRsp,
    output logic [7:0]                accOut,
    output logic [7:0]                idxOut,
    output logic [15:0]               pcOut,
    output logic [15:0]               stackAddr,
    output logic [4:0]                flagsOut,
    output logic [3:0]                serviceVec,
    output logic                      serviceReq
);
    import crs_pkg::*;

    logic [7:0]  acc_q;
    logic [7:0]  acc_d;
    logic [7:0]  idx_q;
    logic [7:0]  idx_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [5:0]  sp_q;
    logic [5:0]  sp_d;
    logic [3:0]  pend_q;
    logic [3:0]  pend_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        err_q;
    logic        err_d;
    logic [4:0]  flags;

    // apb decode
    wire setupPh  = apbReq.psel && !apbReq.penable;
    wire accessPh = apbReq.psel && apbReq.penable;
    wire wrEn     = accessPh && apbReq.pwrite && !err_q;
    wire hitAcc   = apbReq.paddr == `CRS_OFF_ACC;
    wire hitIdx   = apbReq.paddr == `CRS_OFF_IDX;
    wire hitPc    = apbReq.paddr == `CRS_OFF_PC;
    wire hitSp    = apbReq.paddr == `CRS_OFF_SP;
    wire hitFlags = apbReq.paddr == `CRS_OFF_FLAGS;
    wire hitPend  = apbReq.paddr == `CRS_OFF_PEND;
    wire mapped   = hitAcc | hitIdx | hitPc | hitSp | hitFlags | hitPend;
    wire wrAcc    = wrEn && hitAcc;
    wire wrIdx    = wrEn && hitIdx;
    wire wrPc     = wrEn && hitPc;
    wire wrSp     = wrEn && hitSp;
    wire wrFlags  = wrEn && hitFlags;

    // read data latched in the setup phase
    assign rdData_d = !setupPh ? rdData_q :
                      hitAcc   ? {24'h000000, acc_q} :
                      hitIdx   ? {24'h000000, idx_q} :
                      hitPc    ? {16'h0000, pc_q} :
                      hitSp    ? {16'h0000, stackAddr} :
                      hitFlags ? {27'h0000000, flags} :
                      hitPend  ? {28'h0000000, pend_q} : 32'h00000000;
    assign err_d    = setupPh ? !mapped : err_q;

    assign apbRsp.prdata  = rdData_q;
    assign apbRsp.pready  = accessPh;
    assign apbRsp.pslverr = accessPh && err_q;

    // data registers
    assign acc_d = ctl.loadAcc ? ctl.accData :
                   wrAcc       ? apbReq.pwdata[7:0] : acc_q;
    assign idx_d = ctl.loadIdx ? ctl.idxData :
                   wrIdx       ? apbReq.pwdata[7:0] : idx_q;
    assign pc_d  = ctl.loadPc  ? ctl.pcData :
                   ctl.incPc   ? 16'(pc_q + 16'h0001) :
                   wrPc        ? apbReq.pwdata[15:0] : pc_q;

    // stack pointer, six bits wrap inside the stack area
    always_comb begin
        sp_d = sp_q;
        unique case (ctl.stkOp)
            STK_NONE:   sp_d = wrSp ? `CRS_SP_TOP : sp_q;
            STK_PUSH:   sp_d = 6'(sp_q - 6'h01);
            STK_PULL:   sp_d = 6'(sp_q + 6'h01);
            STK_CALL:   sp_d = 6'(sp_q - `CRS_CALL_BYTES);
            STK_RET:    sp_d = 6'(sp_q + `CRS_CALL_BYTES);
            STK_INTE:   sp_d = 6'(sp_q - `CRS_INT_BYTES);
            STK_RTI:    sp_d = 6'(sp_q + `CRS_INT_BYTES);
            STK_REINIT: sp_d = `CRS_SP_TOP;
        endcase
    end
    assign stackAddr = {`CRS_SP_BASE, sp_q};

    // flag updates from the arithmetic unit
    wire [4:0] nibSum = 5'({1'b0, flgUpd.opA[3:0]} + {1'b0, flgUpd.opB[3:0]}
                           + {4'h0, flgUpd.carryIn});
    wire       intEnter = ctl.stkOp == STK_INTE;
    wire [4:0] hwEn;
    wire [4:0] hwVal;
    assign hwEn[`CRS_FLG_H]  = flgUpd.affect[`CRS_FLG_H] && flgUpd.addOp;
    assign hwVal[`CRS_FLG_H] = nibSum > `CRS_NIB_MAX;
    assign hwEn[`CRS_FLG_I]  = flgUpd.affect[`CRS_FLG_I] || intEnter;
    assign hwVal[`CRS_FLG_I] = intEnter || flgUpd.maskVal;
    assign hwEn[`CRS_FLG_N]  = flgUpd.affect[`CRS_FLG_N];
    assign hwVal[`CRS_FLG_N] = flgUpd.result[7];
    assign hwEn[`CRS_FLG_Z]  = flgUpd.affect[`CRS_FLG_Z];
    assign hwVal[`CRS_FLG_Z] = flgUpd.result == 8'h00;
    assign hwEn[`CRS_FLG_C]  = flgUpd.affect[`CRS_FLG_C];
    assign hwVal[`CRS_FLG_C] = flgUpd.carryOut;

    // one cell per flag, unaffected cells hold
    genvar gi;
    generate
        for (gi = 0; gi < `CRS_FLAG_W; gi++) begin : gFlag
            crs_flag_bit #(
                .RST_VAL (1'((`CRS_FLAGS_RST >> gi) & 1))
            ) uFlag (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .hwEn    (hwEn[gi]),
                .hwVal   (hwVal[gi]),
                .swEn    (wrFlags),
                .swVal   (apbReq.pwdata[gi]),
                .flag    (flags[gi])
            );
        end
    endgenerate
    assign flagsOut = flags;

    // pending requests, a new request wins over the acknowledge clear
    wire       maskOn = flags[`CRS_FLG_I];
    wire [3:0] grant  = pend_q & (~pend_q + 4'h1);
    wire [3:0] ackClr = intAck ? serviceVec : 4'h0;
    assign pend_d     = (pend_q & ~ackClr) | irqReq;
    assign serviceVec = maskOn ? 4'h0 : grant;
    assign serviceReq = !maskOn && (pend_q != 4'h0);

    assign accOut = acc_q;
    assign idxOut = idx_q;
    assign pcOut  = pc_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q    <= `CRS_ACC_RST;
            idx_q    <= `CRS_IDX_RST;
            pc_q     <= `CRS_PC_RST;
            sp_q     <= `CRS_SP_TOP;
            pend_q   <= 4'h0;
            rdData_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else begin
            acc_q    <= acc_d;
            idx_q    <= idx_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            pend_q   <= pend_d;
            rdData_q <= rdData_d;
            err_q    <= err_d;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_acc_load_path: assert property (
        ctl.loadAcc |=> acc_q == $past(ctl.accData))
        else $error("accumulator did not take core data");

    a_idx_load_path: assert property (
        ctl.loadIdx |=> idx_q == $past(ctl.idxData))
        else $error("index register did not take core data");

    a_pc_step_one: assert property (
        ctl.incPc && !ctl.loadPc |=> pc_q == 16'($past(pc_q) + 16'h0001))
        else $error("fetch pointer did not step by one");

    a_sp_reinit_top: assert property (
        ctl.stkOp == STK_REINIT |=> stackAddr == 16'h00FF)
        else $error("stack pointer not at top after reinit");

    a_sp_push_pull: assert property (
        ctl.stkOp == STK_PUSH ##1 ctl.stkOp == STK_PULL |=> sp_q == $past(sp_q, 2))
        else $error("push then pull did not restore stack pointer");

    a_stack_base_fixed: assert property (
        stackAddr >= 16'h00C0 && stackAddr <= 16'h00FF)
        else $error("stack address left the stack area");

    a_sp_wrap_push: assert property (
        ctl.stkOp == STK_PUSH && sp_q == 6'h00 |=> stackAddr == 16'h00FF)
        else $error("stack pointer did not wrap");

    a_int_frame_five: assert property (
        ctl.stkOp == STK_INTE |=> 6'($past(sp_q) - sp_q) == 6'h05 && flags[`CRS_FLG_I])
        else $error("interrupt entry frame is not five bytes");

    a_call_frame_two: assert property (
        ctl.stkOp == STK_CALL |=> 6'($past(sp_q) - sp_q) == 6'h02)
        else $error("call frame is not two bytes");

    a_half_carry: assert property (
        flgUpd.affect[`CRS_FLG_H] && flgUpd.addOp
        |=> flags[`CRS_FLG_H] == ($past({1'b0, flgUpd.opA[3:0]} + {1'b0, flgUpd.opB[3:0]}
                                        + {4'h0, flgUpd.carryIn}) > `CRS_NIB_MAX))
        else $error("nibble carry flag wrong");

    a_mask_blocks: assert property (
        maskOn |-> !serviceReq && serviceVec == 4'h0)
        else $error("service offered while masked");

    a_pend_held: assert property (
        irqReq[`CRS_IRQ_TMR] && maskOn ##1 maskOn |-> pend_q[`CRS_IRQ_TMR] && !serviceReq)
        else $error("masked request not held");

    a_nz_result: assert property (
        flgUpd.affect[`CRS_FLG_Z] && flgUpd.affect[`CRS_FLG_N]
        |=> flags[`CRS_FLG_Z] == ($past(flgUpd.result) == 8'h00)
            && flags[`CRS_FLG_N] == $past(flgUpd.result[7]))
        else $error("negative or zero flag wrong");

    a_carry_update: assert property (
        flgUpd.affect[`CRS_FLG_C] |=> flags[`CRS_FLG_C] == $past(flgUpd.carryOut))
        else $error("carry flag wrong");

    a_flags_hold: assert property (
        flgUpd.affect == 5'h00 && !intEnter && !wrFlags |=> $stable(flags))
        else $error("unaffected flags changed");

    c_int_entry: cover property (serviceReq ##1 intAck ##1 ctl.stkOp == STK_INTE);
    c_sp_wrap: cover property (ctl.stkOp == STK_PUSH && sp_q == 6'h00);
    c_masked_then_served: cover property (maskOn && irqReq != 4'h0 ##[1:20] serviceReq);
    c_apb_error: cover property (apbRsp.pslverr);
endmodule
